/* psw_pkg.sv */
package psw_pkg;
    // Nibble addresses of the status word
    localparam logic [11:0] ADDR_LO = 12'hfb0;
    localparam logic [11:0] ADDR_HI = 12'hfb1;
    // Low nibble bit positions
    localparam int BIT_REG_BANK_EN = 0;
    localparam int BIT_MEM_BANK_EN = 1;
    localparam int BIT_INT_LVL_LO  = 2;
    localparam int BIT_INT_LVL_HI  = 3;
    // High nibble bit positions
    localparam int BIT_SKIP_0 = 0;
    localparam int BIT_SKIP_1 = 1;
    localparam int BIT_SKIP_2 = 2;
    localparam int BIT_CARRY  = 3;
    // Vector word bit positions
    localparam int VEC_BIT_REG_BANK_EN = 6;
    localparam int VEC_BIT_MEM_BANK_EN = 7;
    // Reset values
    localparam logic [1:0] INT_LEVEL_RST = 2'h0;
    localparam logic [2:0] SKIP_RST      = 3'h0;
    // Access width codes
    localparam logic [1:0] ACC_BIT    = 2'h0;
    localparam logic [1:0] ACC_NIBBLE = 2'h1;
    localparam logic [1:0] ACC_BYTE   = 2'h2;
    // Interrupt levels
    localparam logic [1:0] LVL_ALL  = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_NONE = 2'h2;
    // Carry operations
    typedef enum logic [3:0] {
        C_NONE  = 4'h0,
        C_SET   = 4'h1,
        C_CLR   = 4'h2,
        C_INV   = 4'h3,
        C_ARITH = 4'h4,
        C_LOAD  = 4'h5,
        C_AND   = 4'h6,
        C_OR    = 4'h7,
        C_XOR   = 4'h8
    } carry_op_t;
endpackage

/* psw_int_gate.sv */
`timescale 1ns/100ps
module psw_int_gate (
    input  wire logic [1:0] level_i,
    input  wire logic       req_i,
    input  wire logic       req_high_i,
    output logic            allow_o,
    output logic [1:0]      next_level_o
);
    // Gate requests by the current nesting level
    always_comb begin
        unique case (level_i)
            psw_pkg::LVL_ALL:  allow_o = req_i;
            psw_pkg::LVL_HIGH: allow_o = req_i & req_high_i;
            default:           allow_o = 1'b0;   // Level 2 and undefined 3 block
        endcase
        // Saturate so raising the level never enters the undefined pattern
        next_level_o = (level_i >= psw_pkg::LVL_NONE) ? psw_pkg::LVL_NONE
                                                       : level_i + 2'h1;
    end
endmodule // psw_int_gate

/* psw_bank_sel.sv */
`timescale 1ns/100ps
module psw_bank_sel (
    input  wire logic       mem_bank_enable_i,
    input  wire logic       reg_bank_enable_i,
    input  wire logic [3:0] mem_bank_select_i,
    input  wire logic [3:0] reg_bank_select_i,
    input  wire logic [7:0] direct_addr_i,
    output logic [3:0]      mem_bank_o,
    output logic [1:0]      reg_bank_o
);
    // Restricted mode: low half maps to bank 0, high half to bank 15
    always_comb begin
        if (mem_bank_enable_i) begin
            mem_bank_o = mem_bank_select_i;
        end else begin
            mem_bank_o = direct_addr_i[7] ? 4'hf : 4'h0;
        end
        reg_bank_o = reg_bank_enable_i ? reg_bank_select_i[1:0] : 2'h0;
    end
endmodule // psw_bank_sel

/* program_status_word.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Eight bits at two nibble addresses
// - Bit, nibble writes; byte reads; always reachable
// - Push on call or interrupt, restore after
// - Reset clears levels, skips; banks from vector
// - Level gates interrupt servicing
// - Entry pushes level, raises it; return restores
// - Memory bank enable restricts data addressing
// - Register bank enable picks working bank
// - Register bank enable from vector bit 6
// - Memory bank enable from vector bit 7
// - Register bank enable at low bit zero
// - Skip flags automatic, byte read only
// - Arithmetic carry reflects overflow or borrow
// - Carry retained across reset
// - Carry changed only by listed operations
// - Set, clear, invert, test-and-skip carry
// - Carry to or from memory bit
// - AND, OR, XOR bit into carry
// - Interrupt pushes and restores carry
module program_status_word (
    input  wire logic                      CLK_I,
    input  wire logic                      SYS_RST_I,
    // Register access from the core
    input  wire logic [11:0]               ADDR_I,
    input  wire logic                      RD_I,
    input  wire logic                      WR_I,
    input  wire logic [1:0]                WIDTH_I,
    input  wire logic [1:0]                BIT_SEL_I,
    input  wire logic [3:0]                WDATA_I,
    output logic [7:0]                     RDATA_O,
    output logic                           HIT_O,
    // Vector word loading
    input  wire logic                      VEC_LOAD_I,
    input  wire logic [7:0]                VEC_WORD_I,
    // Stack save and restore
    input  wire logic                      SAVE_I,
    input  wire logic                      SAVE_FULL_I,
    output logic [7:0]                     SAVE_DATA_O,
    input  wire logic                      RESTORE_I,
    input  wire logic                      RESTORE_FULL_I,
    input  wire logic [7:0]                RESTORE_DATA_I,
    // Interrupt gating
    input  wire logic                      INT_REQ_I,
    input  wire logic                      INT_REQ_HIGH_I,
    input  wire logic                      INT_ACCEPT_I,
    output logic                           INT_ALLOW_O,
    // Skip conditions from the execution unit
    input  wire logic                      SKIP_UPDATE_I,
    input  wire logic [2:0]                SKIP_FLAGS_I,
    // Carry operations
    input  wire psw_pkg::carry_op_t        CARRY_OP_I,
    input  wire logic                      ARITH_CARRY_I,
    input  wire logic                      MEM_BIT_I,
    output logic                           CARRY_O,
    output logic                           CARRY_SKIP_O,
    // Bank selection
    input  wire logic [3:0]                MEM_BANK_SELECT_I,
    input  wire logic [3:0]                REG_BANK_SELECT_I,
    input  wire logic [7:0]                DIRECT_ADDR_I,
    output logic [3:0]                     MEM_BANK_O,
    output logic [1:0]                     REG_BANK_O,
    output logic                           MEM_BANK_ENABLE_O,
    output logic                           REG_BANK_ENABLE_O,
    output logic [1:0]                     INT_LEVEL_O
);
    logic [1:0] int_level_ff;
    logic [1:0] nxt_int_level;
    logic       mem_bank_enable_ff;
    logic       nxt_mem_bank_enable;
    logic       reg_bank_enable_ff;
    logic       nxt_reg_bank_enable;
    logic [2:0] skip_ff;
    logic [2:0] nxt_skip;
    logic       carry_ff;
    logic       nxt_carry;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       hit_ff;
    logic       nxt_hit;
    logic [7:0] save_ff;
    logic [7:0] nxt_save;
    logic       sel_lo;
    logic       sel_hi;
    logic [3:0] lo_nib;
    logic [3:0] hi_nib;
    logic [1:0] raised_level;

    // Nibble decode, independent of the memory bank enable
    // address decode
    assign sel_lo = (ADDR_I == psw_pkg::ADDR_LO);
    assign sel_hi = (ADDR_I == psw_pkg::ADDR_HI);

    assign lo_nib = {int_level_ff, mem_bank_enable_ff, reg_bank_enable_ff};
    assign hi_nib = {carry_ff, skip_ff};

    // Level gating and next nesting level
    // level gating
    psw_int_gate u_int_gate (
        .level_i      (int_level_ff),
        .req_i        (INT_REQ_I),
        .req_high_i   (INT_REQ_HIGH_I),
        .allow_o      (INT_ALLOW_O),
        .next_level_o (raised_level)
    );

    psw_bank_sel u_bank_sel (
        .mem_bank_enable_i (mem_bank_enable_ff),
        .reg_bank_enable_i (reg_bank_enable_ff),
        .mem_bank_select_i (MEM_BANK_SELECT_I),
        .reg_bank_select_i (REG_BANK_SELECT_I),
        .direct_addr_i     (DIRECT_ADDR_I),
        .mem_bank_o        (MEM_BANK_O),
        .reg_bank_o        (REG_BANK_O)
    );

    // Low nibble: levels and bank enables
    always_comb begin
        nxt_int_level       = int_level_ff;
        nxt_mem_bank_enable = mem_bank_enable_ff;
        nxt_reg_bank_enable = reg_bank_enable_ff;
        // Software writes; leaves race-free ordering to software
        if (WR_I && sel_lo) begin
            if (WIDTH_I == psw_pkg::ACC_NIBBLE) begin
                // Level bits only; bank enables are bit-addressable
                nxt_int_level = WDATA_I[psw_pkg::BIT_INT_LVL_HI:psw_pkg::BIT_INT_LVL_LO];
            end else if (WIDTH_I == psw_pkg::ACC_BIT) begin
                unique case (BIT_SEL_I)
                    2'h0: nxt_reg_bank_enable = WDATA_I[0];
                    2'h1: nxt_mem_bank_enable = WDATA_I[0];
                    2'h2: nxt_int_level[0]    = WDATA_I[0];
                    2'h3: nxt_int_level[1]    = WDATA_I[0];
                endcase
            end
        end
        if (RESTORE_I) begin
            // A call image carries no level; only an interrupt image restores it
            if (RESTORE_FULL_I) begin
                nxt_int_level = RESTORE_DATA_I[psw_pkg::BIT_INT_LVL_HI:psw_pkg::BIT_INT_LVL_LO];
            end
            nxt_mem_bank_enable = RESTORE_DATA_I[psw_pkg::BIT_MEM_BANK_EN];
            nxt_reg_bank_enable = RESTORE_DATA_I[psw_pkg::BIT_REG_BANK_EN];
        end
        if (INT_ACCEPT_I) begin
            nxt_int_level = raised_level;
        end
        if (VEC_LOAD_I) begin
            nxt_mem_bank_enable = VEC_WORD_I[psw_pkg::VEC_BIT_MEM_BANK_EN];
            nxt_reg_bank_enable = VEC_WORD_I[psw_pkg::VEC_BIT_REG_BANK_EN];
        end
        if (SYS_RST_I) begin
            nxt_int_level = psw_pkg::INT_LEVEL_RST;
        end
    end

    // Bank enables have no constant reset; the vector word supplies them
    always_ff @(posedge CLK_I) begin
        int_level_ff       <= nxt_int_level;
        mem_bank_enable_ff <= nxt_mem_bank_enable;
        reg_bank_enable_ff <= nxt_reg_bank_enable;
    end

    // High nibble: skip flags and carry
    always_comb begin
        nxt_skip  = skip_ff;
        nxt_carry = carry_ff;
        if (SKIP_UPDATE_I) begin
            nxt_skip = SKIP_FLAGS_I;
        end
        unique case (CARRY_OP_I)
            psw_pkg::C_SET:   nxt_carry = 1'b1;
            psw_pkg::C_CLR:   nxt_carry = 1'b0;
            psw_pkg::C_INV:   nxt_carry = ~carry_ff;
            psw_pkg::C_ARITH: nxt_carry = ARITH_CARRY_I;
            psw_pkg::C_LOAD:  nxt_carry = MEM_BIT_I;
            psw_pkg::C_AND:   nxt_carry = carry_ff & MEM_BIT_I;
            psw_pkg::C_OR:    nxt_carry = carry_ff | MEM_BIT_I;
            psw_pkg::C_XOR:   nxt_carry = carry_ff ^ MEM_BIT_I;
            default:          nxt_carry = carry_ff;
        endcase
        if (WR_I && sel_hi && WIDTH_I == psw_pkg::ACC_BIT
            && BIT_SEL_I == 2'(psw_pkg::BIT_CARRY)) begin
            nxt_carry = WDATA_I[0];
        end
        if (RESTORE_I && RESTORE_FULL_I) begin
            nxt_carry = RESTORE_DATA_I[4 + psw_pkg::BIT_CARRY];
        end
        if (SYS_RST_I) begin
            nxt_skip = psw_pkg::SKIP_RST;
        end
    end

    always_ff @(posedge CLK_I) begin
        skip_ff  <= nxt_skip;
        carry_ff <= nxt_carry;
    end

    // Read data; low-address bit and nibble reads return one nibble, high-address reads carry only, low-address byte reads both
    always_comb begin
        nxt_rdata = 8'h00;
        nxt_hit   = 1'b0;
        if (RD_I) begin
            if (WIDTH_I == psw_pkg::ACC_BYTE && sel_lo) begin
                nxt_rdata = {hi_nib, lo_nib};
                nxt_hit   = 1'b1;
            end else if (sel_lo) begin
                nxt_rdata = {4'h0, lo_nib};
                nxt_hit   = 1'b1;
            end else if (sel_hi) begin
                nxt_rdata = {4'h0, carry_ff, 3'h0};
                nxt_hit   = 1'b1;
            end
        end
        if (SYS_RST_I) begin
            nxt_rdata = 8'h00;
            nxt_hit   = 1'b0;
        end
    end

    // Stack image; a call saves only the bank enables
    always_comb begin
        nxt_save = save_ff;
        if (SAVE_I) begin
            nxt_save = SAVE_FULL_I ? {hi_nib, lo_nib}
                                   : {6'h00, mem_bank_enable_ff, reg_bank_enable_ff};
        end
        if (SYS_RST_I) begin
            nxt_save = 8'h00;
        end
    end

    always_ff @(posedge CLK_I) begin
        rdata_ff <= nxt_rdata;
        hit_ff   <= nxt_hit;
        save_ff  <= nxt_save;
    end

    // Outputs
    assign RDATA_O           = rdata_ff;
    assign HIT_O             = hit_ff;
    assign SAVE_DATA_O       = save_ff;
    assign CARRY_O           = carry_ff;
    assign CARRY_SKIP_O      = carry_ff;
    assign MEM_BANK_ENABLE_O = mem_bank_enable_ff;
    assign REG_BANK_ENABLE_O = reg_bank_enable_ff;
    assign INT_LEVEL_O       = int_level_ff;
endmodule // program_status_word

/* psw_checker_assertions.sv */
`timescale 1ns/100ps
module psw_checker (
    input  wire logic               CLK_I,
    input  wire logic               SYS_RST_I,
    input  wire logic [11:0]        ADDR_I,
    input  wire logic               RD_I,
    input  wire logic               WR_I,
    input  wire logic [1:0]         WIDTH_I,
    input  wire logic [7:0]         RDATA_O,
    input  wire logic               HIT_O,
    input  wire logic               VEC_LOAD_I,
    input  wire logic [7:0]         VEC_WORD_I,
    input  wire logic               RESTORE_I,
    input  wire logic               INT_REQ_I,
    input  wire logic               INT_REQ_HIGH_I,
    input  wire logic               INT_ACCEPT_I,
    input  wire logic               INT_ALLOW_O,
    input  wire logic [1:0]         INT_LEVEL_O,
    input  wire psw_pkg::carry_op_t CARRY_OP_I,
    input  wire logic               CARRY_O,
    input  wire logic               CARRY_SKIP_O,
    input  wire logic [3:0]         MEM_BANK_SELECT_I,
    input  wire logic [3:0]         REG_BANK_SELECT_I,
    input  wire logic [7:0]         DIRECT_ADDR_I,
    input  wire logic [3:0]         MEM_BANK_O,
    input  wire logic [1:0]         REG_BANK_O,
    input  wire logic               MEM_BANK_ENABLE_O,
    input  wire logic               REG_BANK_ENABLE_O
);
    // One domain, reset masks all checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    rst_clear_a: assert property ($fell(SYS_RST_I) |-> INT_LEVEL_O == 2'h0 && !HIT_O)
        else $error("level or hit not cleared by reset");
    vec_load_a: assert property (VEC_LOAD_I |=> MEM_BANK_ENABLE_O == $past(VEC_WORD_I[7])
        && REG_BANK_ENABLE_O == $past(VEC_WORD_I[6]))
        else $error("bank enables not taken from vector");
    level_raise_a: assert property (INT_ACCEPT_I && INT_LEVEL_O < 2'h2
        |=> INT_LEVEL_O == $past(INT_LEVEL_O) + 2'h1) else $error("level not raised");
    allow_gate_a: assert property (INT_LEVEL_O != 2'h3 |-> INT_ALLOW_O == (INT_REQ_I
        && (INT_LEVEL_O == 2'h0 || (INT_LEVEL_O == 2'h1 && INT_REQ_HIGH_I))))
        else $error("interrupt gate wrong for level");
    byte_read_a: assert property (RD_I && WIDTH_I == 2'h2 && ADDR_I == 12'hfb0
        |=> HIT_O && RDATA_O[7] == $past(CARRY_O) && RDATA_O[3:0] == {$past(INT_LEVEL_O),
        $past(MEM_BANK_ENABLE_O), $past(REG_BANK_ENABLE_O)}) else $error("byte image wrong");
    carry_set_a: assert property (CARRY_OP_I == psw_pkg::C_SET && !WR_I && !RESTORE_I
        |=> CARRY_O) else $error("carry not set");
    carry_inv_a: assert property (CARRY_OP_I == psw_pkg::C_INV && !WR_I && !RESTORE_I
        |=> CARRY_O != $past(CARRY_O)) else $error("carry not inverted");
    carry_hold_a: assert property (CARRY_OP_I == psw_pkg::C_NONE && !WR_I && !RESTORE_I
        |=> $stable(CARRY_O)) else $error("carry changed without cause");
    skip_on_carry_a: assert property (CARRY_SKIP_O == CARRY_O)
        else $error("test and skip does not follow carry");
    mem_bank_a: assert property (MEM_BANK_O == (MEM_BANK_ENABLE_O ? MEM_BANK_SELECT_I
        : {4{DIRECT_ADDR_I[7]}})) else $error("memory bank wrong");
    reg_bank_a: assert property (REG_BANK_O == (REG_BANK_ENABLE_O ? REG_BANK_SELECT_I[1:0]
        : 2'h0)) else $error("register bank wrong");
endmodule // psw_checker

bind program_status_word psw_checker chk_u (.*);

/* psw_core_model.sv */
`timescale 1ns/100ps
module psw_core_model (
    input  wire logic       clk_i,
    input  wire logic       save_i,
    input  wire logic       restore_i,
    input  wire logic [7:0] save_data_i,
    output logic [7:0]      restore_data_o = 8'h5a
);
    logic [7:0] stack_q[$];
    logic       save_ff = 1'b0;
    // Stack of saved images; empty stack inverts the last shown value each cycle, so a stale image recurs every other cycle
    // push then pop whole image
    always @(posedge clk_i) begin
        save_ff <= save_i;
        if (save_ff) stack_q.push_back(save_data_i);
        if (restore_i && stack_q.size() > 0) void'(stack_q.pop_back());
        restore_data_o <= (stack_q.size() > 0) ? stack_q[stack_q.size() - 1] : ~restore_data_o;
    end
endmodule // psw_core_model

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic [11:0]        ADDR_I;
    logic [7:0]         VEC_WORD_I, RDATA_O, SAVE_DATA_O, RESTORE_DATA_I, DIRECT_ADDR_I, sv_img;
    logic [3:0]         WDATA_I, MEM_BANK_SELECT_I, REG_BANK_SELECT_I, MEM_BANK_O;
    logic [2:0]         SKIP_FLAGS_I, e_s;
    logic [1:0]         WIDTH_I, BIT_SEL_I, REG_BANK_O, INT_LEVEL_O, e_l;
    logic               CLK_I, SYS_RST_I, RD_I, WR_I, HIT_O, VEC_LOAD_I, SAVE_I, SAVE_FULL_I;
    logic               RESTORE_I, RESTORE_FULL_I, INT_REQ_I, INT_REQ_HIGH_I, INT_ACCEPT_I;
    logic               INT_ALLOW_O, SKIP_UPDATE_I, ARITH_CARRY_I, MEM_BIT_I, CARRY_O;
    logic               CARRY_SKIP_O, MEM_BANK_ENABLE_O, REG_BANK_ENABLE_O, e_c, e_m, e_r;
    psw_pkg::carry_op_t CARRY_OP_I;
    logic [7:0]         exp_q[$];
    int                 num_errors = 0, comparisons = 0, cycles = 0;

    program_status_word dut_u (.*);
    psw_core_model core_u (.clk_i(CLK_I), .save_i(SAVE_I), .restore_i(RESTORE_I),
        .save_data_i(SAVE_DATA_O), .restore_data_o(RESTORE_DATA_I));

    // Free-running clock
    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (e !== g) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    // Strobes drop one cycle after rising; bank and request inputs wander
    task automatic clr;
        @(posedge CLK_I);
        {RD_I, WR_I, VEC_LOAD_I, SAVE_I, RESTORE_I, INT_ACCEPT_I, SKIP_UPDATE_I} <= '0;
        CARRY_OP_I <= psw_pkg::C_NONE;
        {MEM_BANK_SELECT_I, REG_BANK_SELECT_I, DIRECT_ADDR_I} <= 16'($urandom);
        {INT_REQ_I, INT_REQ_HIGH_I} <= 2'($urandom);
    endtask

    task automatic rd_byte;
        @(posedge CLK_I);
        RD_I <= 1'b1;
        WIDTH_I <= psw_pkg::ACC_BYTE;
        ADDR_I <= psw_pkg::ADDR_LO;
        exp_q.push_back({e_c, e_s, e_l, e_m, e_r});
        clr();
    endtask

    task automatic wr(input logic [11:0] a, input logic [1:0] w, b, input logic [3:0] d);
        @(posedge CLK_I);
        // requests held off during the write
        INT_REQ_I <= 1'b0;
        {WR_I, ADDR_I, WIDTH_I, BIT_SEL_I, WDATA_I} <= {1'b1, a, w, b, d};
        clr();
    endtask

    task automatic vec(input logic [7:0] v);
        @(posedge CLK_I);
        VEC_LOAD_I <= 1'b1;
        VEC_WORD_I <= v;
        {e_m, e_r} = v[7:6];
        clr();
    endtask

    task automatic rst(input logic [7:0] v);
        @(posedge CLK_I);
        SYS_RST_I <= 1'b1;
        VEC_LOAD_I <= 1'b1;
        VEC_WORD_I <= v;
        repeat (5) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        {e_l, e_s, e_m, e_r} = {5'h0, v[7:6]};
        clr();
    endtask

    task automatic cop(input psw_pkg::carry_op_t o);
        logic a, m;
        a = 1'($urandom);
        m = 1'($urandom);
        @(posedge CLK_I);
        {CARRY_OP_I, ARITH_CARRY_I, MEM_BIT_I} <= {o, a, m};
        case (o)
            psw_pkg::C_SET:   e_c = 1'b1;
            psw_pkg::C_CLR:   e_c = 1'b0;
            psw_pkg::C_INV:   e_c = ~e_c;
            psw_pkg::C_ARITH: e_c = a;
            psw_pkg::C_LOAD:  e_c = m;
            psw_pkg::C_AND:   e_c = e_c & m;
            psw_pkg::C_OR:    e_c = e_c | m;
            psw_pkg::C_XOR:   e_c = e_c ^ m;
            default:          e_c = e_c;
        endcase
        clr();
    endtask

    // Every answer pops the oldest note; a stray hit meets an unknown note
    always @(negedge CLK_I) begin
        if (HIT_O === 1'b1) chk8("rdata", exp_q.size() ? exp_q.pop_front() : 'x, RDATA_O);
    end

    // Hang guard, far above the roughly 150 cycles needed
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        {ADDR_I, RD_I, WR_I, WIDTH_I, BIT_SEL_I, WDATA_I, SAVE_I, SAVE_FULL_I} = '0;
        {RESTORE_I, RESTORE_FULL_I, INT_REQ_I, INT_REQ_HIGH_I, INT_ACCEPT_I} = '0;
        {SKIP_UPDATE_I, SKIP_FLAGS_I, ARITH_CARRY_I, MEM_BIT_I, DIRECT_ADDR_I} = '0;
        {MEM_BANK_SELECT_I, REG_BANK_SELECT_I} = '0;
        // Carry has no reset; clear it once so no check ever meets an unknown
        CARRY_OP_I = psw_pkg::C_CLR;
        e_c = 1'b0;
        {SYS_RST_I, VEC_LOAD_I, VEC_WORD_I} = 10'h200;
        void'($urandom(32'h966d8055));
        rst(8'h80);
        cop(psw_pkg::C_CLR);
        rd_byte();
        repeat (4) begin
            vec(8'($urandom));
            rd_byte();
        end
        repeat (2) for (int k = 0; k < 9; k++) begin
            cop(psw_pkg::carry_op_t'(k));
            rd_byte();
        end
        @(posedge CLK_I);
        {SKIP_UPDATE_I, SKIP_FLAGS_I} <= 4'hd;
        e_s = 3'h5;
        clr();
        rd_byte();
        wr(psw_pkg::ADDR_HI, psw_pkg::ACC_BIT, 2'h3, 4'h1);
        e_c = 1'b1;
        wr(psw_pkg::ADDR_HI, psw_pkg::ACC_NIBBLE, 2'h0, 4'h0);
        wr(psw_pkg::ADDR_HI, psw_pkg::ACC_BIT, 2'h0, 4'h0);
        rd_byte();
        wr(psw_pkg::ADDR_LO, psw_pkg::ACC_BIT, 2'h1, {3'h0, ~e_m});
        e_m = ~e_m;
        wr(psw_pkg::ADDR_LO, psw_pkg::ACC_NIBBLE, 2'h0, 4'h7);
        e_l = 2'h1;
        rd_byte();
        sv_img = {e_c, e_s, e_l, e_m, e_r};
        @(posedge CLK_I);
        {INT_ACCEPT_I, SAVE_I, SAVE_FULL_I, VEC_LOAD_I, VEC_WORD_I} <= {4'hf, 8'h40};
        {e_l, e_m, e_r} = 4'h9;
        clr();
        rd_byte();
        cop(psw_pkg::C_INV);
        @(posedge CLK_I);
        {RESTORE_I, RESTORE_FULL_I} <= 2'h3;
        {e_c, e_l, e_m, e_r} = {sv_img[7], sv_img[3:0]};
        clr();
        rd_byte();
        @(posedge CLK_I);
        {RD_I, WIDTH_I, ADDR_I} <= {1'b1, psw_pkg::ACC_BYTE, 12'hfb2};
        clr();
        rst(8'hc0);
        rd_byte();
        @(posedge CLK_I);
        {SAVE_I, SAVE_FULL_I, INT_ACCEPT_I} <= 3'h5;
        sv_img = {6'h0, e_m, e_r};
        e_l = 2'h1;
        clr();
        cop(psw_pkg::C_INV);
        vec(8'h00);
        @(posedge CLK_I);
        {RESTORE_I, RESTORE_FULL_I} <= 2'h2;
        {e_m, e_r} = sv_img[1:0];
        clr();
        rd_byte();
        repeat (3) @(posedge CLK_I);
        chk8("pending", 8'h00, 8'(exp_q.size()));
        report_and_stop();
    end
endmodule // tb_top
